// File: verilog/irq_pkg.sv
/*
 * constants, types and carriers for the interrupt aggregation block.
 * assumes one 50 MHz clock, AHB-Lite register access with word offsets.
 */
// Behaviour
// - twelve sticky pin flags, bit n for pin n+1, set by the pin's trigger.
// - writing one clears a pin flag; all flags are zero after reset.
// - request pin is push-pull when drive bit is 0, open drain when 1.
// - output block bit at 1 keeps the request pin deasserted.
// - a group mask bit at 1 blocks that group from the request.
// - every valid group mask bit (GRP_VALID) resets to 1, every group starts blocked.
// - other sources set their flag on the rising edge of the condition.
package irq_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NPIN          = 12;
    localparam int NGRP          = 16;
    localparam int TRIG_FIELD_W  = 2;
    localparam int TRIG_W        = NPIN * TRIG_FIELD_W;
    localparam int SETUP_W       = 2;

    // ****************************************************************
    // register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [15:0] IDX_FLAGS    = 16'h4015;
    localparam logic [15:0] IDX_SETUP    = 16'h4017;
    localparam logic [15:0] IDX_GMASK    = 16'h4018;
    localparam logic [15:0] IDX_TRIG     = 16'h4020;
    localparam logic [15:0] IDX_SRC_STAT = 16'h4021;
    localparam logic [15:0] IDX_SRC_CLR  = 16'h4022;
    localparam logic [15:0] IDX_SRC_EN   = 16'h4023;
    localparam int          IDX_LSB      = 2;
    localparam int          IDX_MSB      = 17;

    // ****************************************************************
    // fields and reset values
    // ****************************************************************
    localparam int          SETUP_OD_BIT    = 1;
    localparam int          SETUP_BLOCK_BIT = 0;
    localparam int          GRP_PIN_BIT     = 13;
    localparam logic [15:0] GRP_VALID       = 16'hf9b3;
    localparam logic [15:0] SRC_VALID       = 16'hd9b3;
    localparam logic [15:0] GMASK_RST       = 16'hf9b3;
    localparam logic [1:0]  SETUP_RST       = 2'h2;
    localparam logic [11:0] FLAGS_RST       = 12'h000;
    localparam logic [15:0] SRC_RST         = 16'h0000;
    localparam logic [23:0] TRIG_RST        = 24'h000000;

    // ****************************************************************
    // bus codes
    // ****************************************************************
    localparam int         HTRANS_ACT_BIT = 1;
    localparam logic [2:0] HSIZE_WORD     = 3'h2;

    typedef enum logic [1:0] {
        TRIG_RISE,
        TRIG_FALL,
        TRIG_BOTH,
        TRIG_HIGH
    } trig_mode_t;

    typedef struct packed {
        logic [15:0] idx;
        logic        wr;
    } ahb_cmd_t;

    typedef struct packed {
        logic open_drain;
        logic out_block;
    } pin_setup_t;

endpackage : irq_pkg

// File: verilog/pin_sync.sv
/*
 * three-stage synchroniser bank for pins from outside the clock domain.
 * assumes inputs are asynchronous levels; a change counts once stages
 * two and three agree.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // ****************************************************************
    // per bit chain
    // ****************************************************************
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                s1_r[i] <= 1'h0;
                s2_r[i] <= 1'h0;
                s3_r[i] <= 1'h0;
                q[i]    <= 1'h0;
            end else begin
                s1_r[i] <= d[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                // one-cycle glitch in stage two never reaches q
                if (s2_r[i] == s3_r[i]) begin
                    q[i] <= s3_r[i];
                end
            end
        end
    end

endmodule : pin_sync

// File: verilog/pin_trigger.sv
/*
 * trigger detector for one pin, selectable edge or level.
 * assumes a synchronised level on the same clock.
 */
`timescale 1ns/1ps
module pin_trigger (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              level,
    input  irq_pkg::trig_mode_t    mode,
    output logic                   hit
);

    logic prev_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev_r <= 1'h0;
        end else begin
            prev_r <= level;
        end
    end

    // a pin already high at reset release shows as one rising edge
    always_comb begin
        case (mode)
            irq_pkg::TRIG_RISE: hit = level & ~prev_r;
            irq_pkg::TRIG_FALL: hit = ~level & prev_r;
            irq_pkg::TRIG_BOTH: hit = level ^ prev_r;
            irq_pkg::TRIG_HIGH: hit = level;
            default:            hit = 1'h0;
        endcase
    end

endmodule : pin_trigger

// File: verilog/pmic_irq_aggregation.sv
/*
 * interrupt aggregation: pin flags, group masks, request pin drive,
 * AHB-Lite register slave.
 * assumes single-word AHB transfers with no pipelined back-to-back
 * accesses, and asynchronous pin and source inputs.
 */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module pmic_irq_aggregation (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [11:0] gpio_in,
    input  wire logic [15:0] group_src_in,
    output logic             irq_b_o,
    output logic             irq_b_oe,
    output logic             event_irq
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    irq_pkg::ahb_cmd_t   cmd_r;
    irq_pkg::pin_setup_t setup_r;
    logic [11:0]         flags_r;
    logic [15:0]         gmask_r;
    logic [23:0]         trig_r;
    logic [15:0]         src_stat_r;
    logic [15:0]         src_en_r;
    logic [15:0]         src_prev_r;
    logic                req_r;
    logic                req_nxt;
    logic [11:0]         gpio_lvl;
    logic [15:0]         src_lvl;
    logic [11:0]         pin_hit;
    logic [15:0]         src_rise;
    logic [11:0]         flag_clr;
    logic [11:0]         clr_only;
    logic [15:0]         src_clr;
    logic [15:0]         grp_pend;
    logic [15:0]         unmasked;
    logic                take;
    logic                addr_ok;
    logic [15:0]         a_idx;
    logic [31:0]         rd_mux;
    logic                wr_flags;
    logic                wr_setup;
    logic                wr_gmask;
    logic                wr_trig;
    logic                wr_src_clr;
    logic                wr_src_en;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    pin_sync #(.W(irq_pkg::NPIN)) u_gpio_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (gpio_in),
        .q     (gpio_lvl)
    );

    pin_sync #(.W(irq_pkg::NGRP)) u_src_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (group_src_in),
        .q     (src_lvl)
    );

    // ****************************************************************
    // per pin trigger
    // ****************************************************************
    for (genvar i = 0; i < irq_pkg::NPIN; i++) begin : g_pin
        pin_trigger u_trig (
            .mclk  (mclk),
            .rst_b (rst_b),
            .level (gpio_lvl[i]),
            .mode  (irq_pkg::trig_mode_t'(
                        trig_r[i*irq_pkg::TRIG_FIELD_W +:
                               irq_pkg::TRIG_FIELD_W])),
            .hit   (pin_hit[i])
        );
    end

    // ****************************************************************
    // bus address phase
    // ****************************************************************
    assign take    = hsel && hready && htrans[irq_pkg::HTRANS_ACT_BIT];
    assign addr_ok = (haddr[31:irq_pkg::IDX_MSB+1] == '0)
                     && (haddr[irq_pkg::IDX_LSB-1:0] == '0);
    assign a_idx   = haddr[irq_pkg::IDX_MSB:irq_pkg::IDX_LSB];

    always_comb begin
        rd_mux = '0;
        if (!addr_ok) begin
            rd_mux = '0;
        end else if (a_idx == irq_pkg::IDX_FLAGS) begin
            rd_mux = 32'(flags_r);
        end else if (a_idx == irq_pkg::IDX_SETUP) begin
            rd_mux = 32'(setup_r);
        end else if (a_idx == irq_pkg::IDX_GMASK) begin
            rd_mux = 32'(gmask_r);
        end else if (a_idx == irq_pkg::IDX_TRIG) begin
            rd_mux = 32'(trig_r);
        end else if (a_idx == irq_pkg::IDX_SRC_STAT) begin
            rd_mux = 32'(src_stat_r);
        end else if (a_idx == irq_pkg::IDX_SRC_EN) begin
            rd_mux = 32'(src_en_r);
        end
    end

    // zero wait state; read data sampled in the address phase
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_r     <= '0;
            hrdata    <= '0;
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
        end else begin
            cmd_r.wr  <= take && hwrite && addr_ok
                         && (hsize == irq_pkg::HSIZE_WORD);
            cmd_r.idx <= a_idx;
            hrdata    <= (take && !hwrite) ? rd_mux : '0;
        end
    end

    // ****************************************************************
    // bus data phase write decode
    // ****************************************************************
    always_comb begin
        wr_flags   = 1'h0;
        wr_setup   = 1'h0;
        wr_gmask   = 1'h0;
        wr_trig    = 1'h0;
        wr_src_clr = 1'h0;
        wr_src_en  = 1'h0;
        if (!cmd_r.wr) begin
            wr_flags = 1'h0;
        end else if (cmd_r.idx == irq_pkg::IDX_FLAGS) begin
            wr_flags = 1'h1;
        end else if (cmd_r.idx == irq_pkg::IDX_SETUP) begin
            wr_setup = 1'h1;
        end else if (cmd_r.idx == irq_pkg::IDX_GMASK) begin
            wr_gmask = 1'h1;
        end else if (cmd_r.idx == irq_pkg::IDX_TRIG) begin
            wr_trig = 1'h1;
        end else if (cmd_r.idx == irq_pkg::IDX_SRC_CLR) begin
            wr_src_clr = 1'h1;
        end else if (cmd_r.idx == irq_pkg::IDX_SRC_EN) begin
            wr_src_en = 1'h1;
        end
    end

    assign flag_clr = wr_flags ? hwdata[irq_pkg::NPIN-1:0] : '0;
    assign clr_only = flag_clr & ~pin_hit;
    assign src_clr  = wr_src_clr ? hwdata[irq_pkg::NGRP-1:0] : '0;

    // ****************************************************************
    // configuration registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            setup_r <= irq_pkg::SETUP_RST;
        end else if (wr_setup) begin
            setup_r <= irq_pkg::pin_setup_t'(
                hwdata[irq_pkg::SETUP_OD_BIT:irq_pkg::SETUP_BLOCK_BIT]);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gmask_r <= irq_pkg::GMASK_RST;
        end else if (wr_gmask) begin
            gmask_r <= hwdata[irq_pkg::NGRP-1:0] & irq_pkg::GRP_VALID;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_r <= irq_pkg::TRIG_RST;
        end else if (wr_trig) begin
            trig_r <= hwdata[irq_pkg::TRIG_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            src_en_r <= irq_pkg::SRC_RST;
        end else if (wr_src_en) begin
            src_en_r <= hwdata[irq_pkg::NGRP-1:0] & irq_pkg::SRC_VALID;
        end
    end

    // ****************************************************************
    // sticky flags, set wins over a clear in the same cycle
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= irq_pkg::FLAGS_RST;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | pin_hit;
        end
    end

    assign src_rise = src_lvl & ~src_prev_r & irq_pkg::SRC_VALID;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            src_prev_r <= irq_pkg::SRC_RST;
            src_stat_r <= irq_pkg::SRC_RST;
        end else begin
            src_prev_r <= src_lvl;
            src_stat_r <= (src_stat_r & ~src_clr) | src_rise;
        end
    end

    // ****************************************************************
    // group combine and request pin
    // ****************************************************************
    always_comb begin
        grp_pend = src_stat_r & src_en_r;
        grp_pend[irq_pkg::GRP_PIN_BIT] = |flags_r;
    end

    assign unmasked = grp_pend & ~gmask_r & irq_pkg::GRP_VALID;
    assign req_nxt  = (|unmasked) && !setup_r.out_block;

    // active-low pin; open drain only ever pulls low, pull-up does the rest
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            req_r     <= 1'h0;
            irq_b_o   <= 1'h0;
            irq_b_oe  <= 1'h0;
            event_irq <= 1'h0;
        end else begin
            req_r     <= req_nxt;
            event_irq <= |(src_stat_r & src_en_r);
            if (setup_r.open_drain) begin
                irq_b_o  <= 1'h0;
                irq_b_oe <= req_nxt;
            end else begin
                irq_b_o  <= ~req_nxt;
                irq_b_oe <= 1'h1;
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_pin_set;
        (pin_hit != '0) |=> ((flags_r & $past(pin_hit)) == $past(pin_hit));
    endproperty
    a_pin_set: assert property (p_pin_set)
        else $error("pin trigger did not set its flag");

    property p_flag_clear;
        (clr_only != '0) |=> ((flags_r & $past(clr_only)) == '0);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("written one did not clear a pin flag");

    property p_flags_rst;
        ($past(rst_b) == 1'h0) |-> (flags_r == irq_pkg::FLAGS_RST);
    endproperty
    a_flags_rst: assert property (p_flags_rst)
        else $error("pin flags not zero after reset");

    property p_od_idle;
        (setup_r.open_drain && !req_nxt) |=> !irq_b_oe;
    endproperty
    a_od_idle: assert property (p_od_idle)
        else $error("open drain pin driven while idle");

    property p_cmos_drive;
        !setup_r.open_drain |=> irq_b_oe ##0 (irq_b_o == !req_r);
    endproperty
    a_cmos_drive: assert property (p_cmos_drive)
        else $error("push-pull pin not driven to request level");

    property p_out_block;
        setup_r.out_block |=> !(irq_b_oe && !irq_b_o);
    endproperty
    a_out_block: assert property (p_out_block)
        else $error("request pin asserted while output blocked");

    property p_group_block;
        (unmasked == '0) |=> !req_r;
    endproperty
    a_group_block: assert property (p_group_block)
        else $error("request raised with no unblocked group");

    property p_mask_rst;
        ($past(rst_b) == 1'h0) |-> (gmask_r == irq_pkg::GMASK_RST);
    endproperty
    a_mask_rst: assert property (p_mask_rst)
        else $error("group mask not all blocked after reset");

    property p_src_rise;
        (src_rise != '0)
            |=> ((src_stat_r & $past(src_rise)) == $past(src_rise));
    endproperty
    a_src_rise: assert property (p_src_rise)
        else $error("source rising edge did not set its flag");

    sequence s_live;
        (unmasked != '0) && !setup_r.out_block;
    endsequence

    sequence s_pin_low;
        req_r && irq_b_oe && !irq_b_o;
    endsequence

    sequence s_quiet;
        (unmasked == '0) ##1 (unmasked == '0);
    endsequence

    property p_req_assert;
        s_live |=> s_pin_low;
    endproperty
    a_req_assert: assert property (p_req_assert)
        else $error("request pin not asserted for live group");

    property p_req_release;
        s_quiet |=> !req_r && !(irq_b_oe && !irq_b_o);
    endproperty
    a_req_release: assert property (p_req_release)
        else $error("request pin held with nothing pending");

endmodule : pmic_irq_aggregation

// File: tb/irq_host_model.sv
/*
 * host side of the request pin: resolves the wire from the block's
 * output value and enable, with the integrated pull-up.
 * assumes the host only listens; it never drives the pin.
 */
`timescale 1ns/1ps
module irq_host_model (
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output logic      pin_level,
    output logic      irq_seen
);
    // ****************************************************************
    // wire resolution
    // ****************************************************************
    // released pin floats up, never to a stale driven value
    assign pin_level = pin_oe ? pin_o : 1'b1;
    assign irq_seen  = ~pin_level;
endmodule : irq_host_model

// File: tb/pmic_irq_aggregation_tb.sv
/*
 * self-checking bench: AHB-Lite master tasks, pin and source stimulus,
 * request pin watched through the host model.
 * assumes a zero-wait slave but waits on hready anyway.
 */
`timescale 1ns/1ps
module pmic_irq_aggregation_tb;
    logic        mclk;
    logic        rst_b;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [11:0] gpio_in;
    logic [15:0] group_src_in;
    logic        irq_b_o;
    logic        irq_b_oe;
    logic        event_irq;
    logic        pin_level;
    logic        irq_seen;
    logic [31:0] rd;
    int          bad_count;
    int          compares;
    logic [15:0] bit_m;

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

    assign hready = hreadyout;

    pmic_irq_aggregation dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio_in),
        .group_src_in(group_src_in), .irq_b_o(irq_b_o),
        .irq_b_oe(irq_b_oe), .event_irq(event_irq)
    );

    irq_host_model host (
        .pin_o(irq_b_o), .pin_oe(irq_b_oe),
        .pin_level(pin_level), .irq_seen(irq_seen)
    );

    always #10 mclk = ~mclk;

    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic ahb_xfer(input logic [15:0] idx, input logic wr,
                            input logic [31:0] wdata);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= irq_pkg::HSIZE_WORD;
        haddr  <= {14'h0000, idx, 2'h0};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wdata;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask : ahb_xfer

    task automatic wr_reg(input logic [15:0] idx, input logic [31:0] d);
        ahb_xfer(idx, 1'b1, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] idx);
        ahb_xfer(idx, 1'b0, 32'h00000000);
    endtask : rd_reg

    task automatic settle();
        repeat (8) @(posedge mclk);
    endtask : settle

    // ****************************************************************
    // verdict
    // ****************************************************************
    task automatic report_and_stop();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        report_and_stop();
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin : main
        logic [3:0] rise_x;
        logic [3:0] fall_x;
        mclk = 1'b0;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        gpio_in = 12'h000;
        group_src_in = 16'h0000;
        bad_count = 0;
        compares = 0;
        rise_x = 4'hd;
        fall_x = 4'he;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        rd_reg(irq_pkg::IDX_FLAGS);
        `CHK(rd, 32'h00000000)
        rd_reg(irq_pkg::IDX_SETUP);
        `CHK(rd, 32'h00000002)
        rd_reg(irq_pkg::IDX_GMASK);
        `CHK(rd, 32'h0000f9b3)
        rd_reg(16'h4016);
        `CHK(rd, 32'h00000000)
        wr_reg(16'h4016, 32'hffffffff);
        `CHK(irq_seen, 1'b0)
        // every pin, rising trigger, write-one-to-clear
        for (int n = 0; n < 12; n++) begin
            @(posedge mclk) gpio_in[n] <= 1'b1;
            settle();
            rd_reg(irq_pkg::IDX_FLAGS);
            `CHK(rd, 32'(1) << n)
            wr_reg(irq_pkg::IDX_FLAGS, 32'h0);
            rd_reg(irq_pkg::IDX_FLAGS);
            `CHK(rd, 32'(1) << n)
            `CHK(irq_seen, 1'b0)
            wr_reg(irq_pkg::IDX_FLAGS, 32'(1) << n);
            rd_reg(irq_pkg::IDX_FLAGS);
            `CHK(rd, 32'h0)
            @(posedge mclk) gpio_in[n] <= 1'b0;
            settle();
        end
        // each trigger mode on the last pin
        for (int m = 0; m < 4; m++) begin
            wr_reg(irq_pkg::IDX_TRIG, 32'(m) << 22);
            rd_reg(irq_pkg::IDX_TRIG);
            `CHK(rd, 32'(m) << 22)
            settle();
            wr_reg(irq_pkg::IDX_FLAGS, 32'h00000fff);
            @(posedge mclk) gpio_in[11] <= 1'b1;
            settle();
            rd_reg(irq_pkg::IDX_FLAGS);
            `CHK(rd[11], rise_x[m])
            wr_reg(irq_pkg::IDX_FLAGS, 32'h00000800);
            @(posedge mclk) gpio_in[11] <= 1'b0;
            settle();
            rd_reg(irq_pkg::IDX_FLAGS);
            `CHK(rd[11], fall_x[m])
            wr_reg(irq_pkg::IDX_FLAGS, 32'h00000800);
        end
        wr_reg(irq_pkg::IDX_TRIG, 32'h0);
        // pin group through masks and drive modes
        @(posedge mclk) gpio_in[0] <= 1'b1;
        settle();
        `CHK(irq_seen, 1'b0)
        wr_reg(irq_pkg::IDX_GMASK, 32'h0000d9b3);
        settle();
        `CHK(irq_seen, 1'b1)
        `CHK(irq_b_oe, 1'b1)
        wr_reg(irq_pkg::IDX_SETUP, 32'h3);
        settle();
        `CHK(irq_seen, 1'b0)
        wr_reg(irq_pkg::IDX_SETUP, 32'h0);
        settle();
        `CHK({irq_b_oe, irq_b_o}, 2'h2)
        wr_reg(irq_pkg::IDX_FLAGS, 32'h1);
        settle();
        `CHK({irq_b_oe, irq_b_o}, 2'h3)
        wr_reg(irq_pkg::IDX_SETUP, 32'h2);
        settle();
        `CHK(irq_b_oe, 1'b0)
        `CHK(pin_level, 1'b1)
        @(posedge mclk) gpio_in[0] <= 1'b0;
        wr_reg(irq_pkg::IDX_GMASK, 32'h0000ffff);
        rd_reg(irq_pkg::IDX_GMASK);
        `CHK(rd, 32'h0000f9b3)
        // other groups, one at a time; unused enable bits do not stick
        wr_reg(irq_pkg::IDX_SRC_EN, 32'h0000ffff);
        rd_reg(irq_pkg::IDX_SRC_EN);
        `CHK(rd, 32'h0000d9b3)
        for (int g = 0; g < 16; g++) begin
            bit_m = 16'h0001 << g;
            if ((bit_m & irq_pkg::SRC_VALID) != 16'h0000) begin
                wr_reg(irq_pkg::IDX_GMASK, {16'h0000, 16'hf9b3 ^ bit_m});
                @(posedge mclk) group_src_in[g] <= 1'b1;
                settle();
                rd_reg(irq_pkg::IDX_SRC_STAT);
                `CHK(rd, {16'h0000, bit_m})
                `CHK(irq_seen, 1'b1)
                `CHK(event_irq, 1'b1)
                wr_reg(irq_pkg::IDX_GMASK, 32'h0000f9b3);
                settle();
                `CHK(irq_seen, 1'b0)
                wr_reg(irq_pkg::IDX_SRC_CLR, {16'h0000, bit_m});
                settle();
                rd_reg(irq_pkg::IDX_SRC_STAT);
                `CHK(rd, 32'h0)
                `CHK(event_irq, 1'b0)
                @(posedge mclk) group_src_in[g] <= 1'b0;
                settle();
            end
        end
        // mid-run reset must drop a live flag and reblock every group
        wr_reg(irq_pkg::IDX_GMASK, 32'h0000d9b3);
        @(posedge mclk) gpio_in[4] <= 1'b1;
        settle();
        @(posedge mclk) gpio_in[4] <= 1'b0;
        settle();
        `CHK(irq_seen, 1'b1)
        @(posedge mclk) rst_b <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(irq_seen, 1'b0)
        rst_b <= 1'b1;
        rd_reg(irq_pkg::IDX_FLAGS);
        `CHK(rd, 32'h00000000)
        rd_reg(irq_pkg::IDX_GMASK);
        `CHK(rd, 32'h0000f9b3)
        rd_reg(irq_pkg::IDX_SETUP);
        `CHK(rd, 32'h00000002)
        `CHK(irq_seen, 1'b0)
        report_and_stop();
    end : main
endmodule : pmic_irq_aggregation_tb
